// ==== src/pcg_pkg.sv ====
package pcg_pkg;
  localparam logic [31:0] SYSCTL_BASE        = 32'h400fe000;
  // Register byte offsets within the system-control space.
  localparam logic [11:0] OFF_RUN_ONE        = 12'h104;
  localparam logic [11:0] OFF_DEEP_ZERO      = 12'h120;
  localparam logic [11:0] OFF_SLEEP_ZERO     = 12'h110;
  localparam logic [11:0] OFF_SLEEP_ONE      = 12'h114;
  localparam logic [11:0] OFF_RUN_ZERO       = 12'h100;
  localparam logic [11:0] OFF_DEEP_ONE       = 12'h124;
  localparam logic [11:0] OFF_AUTO_CTRL      = 12'h180;
  localparam logic [11:0] OFF_IRQ_STATUS     = 12'h184;
  localparam logic [11:0] OFF_IRQ_CLEAR      = 12'h188;
  localparam logic [11:0] OFF_IRQ_ENABLE     = 12'h18c;
  // Implemented bits of each gating layout.
  localparam logic [31:0] MASK_GROUP_ONE     = 32'h00071013;
  localparam logic [31:0] MASK_GROUP_ZERO    = 32'h00010008;
  localparam logic [31:0] RST_RUN_ONE        = 32'h00000000;
  localparam logic [31:0] RST_DEEP_ZERO      = 32'h00000040;
  localparam logic [31:0] RST_SLEEP_ONE      = 32'h00000000;
  localparam logic [31:0] RST_SLEEP_ZERO     = 32'h00000000;
  localparam logic [31:0] RST_RUN_ZERO       = 32'h00000000;
  localparam logic [31:0] RST_DEEP_ONE       = 32'h00000000;
  // Bit positions in the group-one layout.
  localparam int BIT_SERIAL_A   = 0;
  localparam int BIT_SERIAL_B   = 1;
  localparam int BIT_SYNC       = 4;
  localparam int BIT_TWO_WIRE   = 12;
  localparam int BIT_CNT_A      = 16;
  localparam int BIT_CNT_B      = 17;
  localparam int BIT_CNT_C      = 18;
  // Bit positions in the group-zero layout, and the automatic-gating bit of the control register.
  localparam int BIT_WATCHDOG   = 3;
  localparam int BIT_CONVERTER  = 16;
  localparam int BIT_AUTO_GATE  = 0;
  // Interrupt status bits.
  localparam int IRQ_FAULT      = 0;
  localparam int IRQ_GATE_CHG   = 1;
  localparam int IRQ_W          = 2;
  localparam int NUM_PERIPH     = 8;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PCG_RUN,
    PCG_SLEEP,
    PCG_DEEP
  } pcg_power_t;
endpackage

// ==== src/pcg_gate_bit.sv ====
`timescale 1ns/100ps
`default_nettype none
// One peripheral's gate: picks the enable by power state and registers it.
module pcg_gate_bit (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire pcg_pkg::pcg_power_t power_state,
  input  wire logic              auto_gate,
  input  wire logic              run_en,
  input  wire logic              sleep_en,
  input  wire logic              deep_en,
  output logic                   gate_q
);
  logic gate_d;

  always_comb begin
    gate_d = run_en;
    if (auto_gate) begin
      case (power_state)
        pcg_pkg::PCG_SLEEP: gate_d = sleep_en;
        pcg_pkg::PCG_DEEP:  gate_d = deep_en;
        default:            gate_d = run_en;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end
endmodule
`default_nettype wire

// ==== src/pcg_top.sv ====
// Contract
// - A set gating bit clocks its peripheral; a clear bit leaves it unclocked.
// - Bus access to an unclocked peripheral raises a bus fault instead.
// - All gating bits reset to zero unless individually noted otherwise.
// - Run, sleep or deep-sleep gating set chosen by current power state.
// - Sleep and deep-sleep sets apply only when automatic gating is selected.
// - Deep-sleep group-zero bit 16 gates the converter clock, read-write.
// - Deep-sleep group-zero bit 3 gates the watchdog clock, read-write.
// - Run group-one bits 18, 17, 16 gate timers 2, 1, 0.
// - Run group-one bit 12 gates the two-wire bus controller.
// - Run group-one bit 4 gates the synchronous serial interface.
// - Run group-one bits 1 and 0 gate serial ports two and one.
// - Deep-sleep group zero at 0x120, run group one at 0x104, base 0x400fe000.
`timescale 1ns/100ps
`default_nettype none
module pcg_top (
  input  wire logic        clock,
  input  wire logic        reset,
  // AXI4-Lite slave.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power state from the power-mode controller.
  input  wire pcg_pkg::pcg_power_t power_state,
  // Peripheral side: one bit per peripheral, order serial_a, serial_b, sync,
  // two_wire, cnt_a, cnt_b, cnt_c, watchdog, converter (index 0..8).
  input  wire logic [8:0]  periph_access,
  output logic [8:0]       periph_clock_en,
  output logic [8:0]       periph_fault,
  output logic             irq
);
  localparam int NP = pcg_pkg::NUM_PERIPH + 1;

  logic [31:0] run_one_q, run_one_d, deep_zero_q, deep_zero_d;
  logic [31:0] sleep_one_q, sleep_one_d, sleep_zero_q, sleep_zero_d;
  logic [31:0] run_zero_q, run_zero_d, deep_one_q, deep_one_d;
  logic        auto_gate_q, auto_gate_d;
  logic [pcg_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [8:0]  fault_q, fault_d;
  logic        irq_q, irq_d;
  logic [NP-1:0] run_en, sleep_en, deep_en, gate_q;
  logic [NP-1:0] gate_prev_q;
  logic        do_write;
  logic [31:0] wmask;

  // Map register bits onto the per-peripheral enables.
  always_comb begin
    run_en  = {run_zero_q[pcg_pkg::BIT_CONVERTER], run_zero_q[pcg_pkg::BIT_WATCHDOG],
               run_one_q[pcg_pkg::BIT_CNT_C], run_one_q[pcg_pkg::BIT_CNT_B],
               run_one_q[pcg_pkg::BIT_CNT_A], run_one_q[pcg_pkg::BIT_TWO_WIRE],
               run_one_q[pcg_pkg::BIT_SYNC],
               run_one_q[pcg_pkg::BIT_SERIAL_B], run_one_q[pcg_pkg::BIT_SERIAL_A]};
    sleep_en = {sleep_zero_q[pcg_pkg::BIT_CONVERTER], sleep_zero_q[pcg_pkg::BIT_WATCHDOG],
                sleep_one_q[pcg_pkg::BIT_CNT_C], sleep_one_q[pcg_pkg::BIT_CNT_B],
                sleep_one_q[pcg_pkg::BIT_CNT_A], sleep_one_q[pcg_pkg::BIT_TWO_WIRE],
                sleep_one_q[pcg_pkg::BIT_SYNC],
                sleep_one_q[pcg_pkg::BIT_SERIAL_B], sleep_one_q[pcg_pkg::BIT_SERIAL_A]};
    deep_en = {deep_zero_q[pcg_pkg::BIT_CONVERTER],
               deep_zero_q[pcg_pkg::BIT_WATCHDOG],
               deep_one_q[pcg_pkg::BIT_CNT_C], deep_one_q[pcg_pkg::BIT_CNT_B],
               deep_one_q[pcg_pkg::BIT_CNT_A], deep_one_q[pcg_pkg::BIT_TWO_WIRE],
               deep_one_q[pcg_pkg::BIT_SYNC],
               deep_one_q[pcg_pkg::BIT_SERIAL_B], deep_one_q[pcg_pkg::BIT_SERIAL_A]};
  end

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_gate
      pcg_gate_bit u_gate (
        .clock       (clock),
        .reset       (reset),
        .power_state (power_state),
        .auto_gate   (auto_gate_q),
        .run_en      (run_en[gi]),
        .sleep_en    (sleep_en[gi]),
        .deep_en     (deep_en[gi]),
        .gate_q      (gate_q[gi])
      );
    end
  endgenerate

  // Write channel: address and data are accepted in either order.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      wmask[i] = wstrb_q[i/8];
    end
    awready_d = awready_q;
    wready_d  = wready_q;
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_write  = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      awaddr_d  = s_axi_awaddr;
      aw_got_d  = 1'b1;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q) begin
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      w_got_d  = 1'b1;
      wready_d = 1'b0;
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      do_write = 1'b1;
      bvalid_d = 1'b1;
      bresp_d  = pcg_pkg::RESP_OKAY;
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
  end

  // Register updates; unimplemented bits are masked so they stay zero.
  always_comb begin
    run_one_d    = run_one_q;
    deep_zero_d  = deep_zero_q;
    sleep_one_d  = sleep_one_q;
    sleep_zero_d = sleep_zero_q;
    run_zero_d   = run_zero_q;
    deep_one_d   = deep_one_q;
    auto_gate_d  = auto_gate_q;
    irq_en_d     = irq_en_q;
    irq_stat_d   = irq_stat_q;
    if (do_write) begin
      if (awaddr_q == pcg_pkg::OFF_RUN_ONE) begin
        run_one_d = ((run_one_q & ~wmask) | (wdata_q & wmask))
                    & pcg_pkg::MASK_GROUP_ONE;
      end else if (awaddr_q == pcg_pkg::OFF_DEEP_ZERO) begin
        deep_zero_d = ((deep_zero_q & ~wmask) | (wdata_q & wmask))
                      & pcg_pkg::MASK_GROUP_ZERO;
      end else if (awaddr_q == pcg_pkg::OFF_SLEEP_ONE) begin
        sleep_one_d = ((sleep_one_q & ~wmask) | (wdata_q & wmask)) & pcg_pkg::MASK_GROUP_ONE;
      end else if (awaddr_q == pcg_pkg::OFF_SLEEP_ZERO) begin
        sleep_zero_d = ((sleep_zero_q & ~wmask) | (wdata_q & wmask)) & pcg_pkg::MASK_GROUP_ZERO;
      end else if (awaddr_q == pcg_pkg::OFF_RUN_ZERO) begin
        run_zero_d = ((run_zero_q & ~wmask) | (wdata_q & wmask)) & pcg_pkg::MASK_GROUP_ZERO;
      end else if (awaddr_q == pcg_pkg::OFF_DEEP_ONE) begin
        deep_one_d = ((deep_one_q & ~wmask) | (wdata_q & wmask)) & pcg_pkg::MASK_GROUP_ONE;
      end else if (awaddr_q == pcg_pkg::OFF_AUTO_CTRL) begin
        if (wstrb_q[0]) begin
          auto_gate_d = wdata_q[pcg_pkg::BIT_AUTO_GATE];
        end
      end else if (awaddr_q == pcg_pkg::OFF_IRQ_CLEAR) begin
        if (wstrb_q[0]) begin
          irq_stat_d = irq_stat_q & ~wdata_q[pcg_pkg::IRQ_W-1:0];
        end
      end else if (awaddr_q == pcg_pkg::OFF_IRQ_ENABLE) begin
        if (wstrb_q[0]) begin
          irq_en_d = wdata_q[pcg_pkg::IRQ_W-1:0];
        end
      end
    end
    // Events are applied after the clear so a simultaneous event is kept.
    if (|(periph_access & ~gate_q)) begin
      irq_stat_d[pcg_pkg::IRQ_FAULT] = 1'b1;
    end
    if (gate_q != gate_prev_q) begin
      irq_stat_d[pcg_pkg::IRQ_GATE_CHG] = 1'b1;
    end
  end

  // Read channel; unmapped reads return zero with OKAY.
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = pcg_pkg::RESP_OKAY;
      if (s_axi_araddr == pcg_pkg::OFF_RUN_ONE) begin
        rdata_d = run_one_q;
      end else if (s_axi_araddr == pcg_pkg::OFF_DEEP_ZERO) begin
        rdata_d = deep_zero_q;
      end else if (s_axi_araddr == pcg_pkg::OFF_SLEEP_ONE) begin
        rdata_d = sleep_one_q;
      end else if (s_axi_araddr == pcg_pkg::OFF_SLEEP_ZERO) begin
        rdata_d = sleep_zero_q;
      end else if (s_axi_araddr == pcg_pkg::OFF_RUN_ZERO) begin
        rdata_d = run_zero_q;
      end else if (s_axi_araddr == pcg_pkg::OFF_DEEP_ONE) begin
        rdata_d = deep_one_q;
      end else if (s_axi_araddr == pcg_pkg::OFF_AUTO_CTRL) begin
        rdata_d = {31'h0, auto_gate_q};
      end else if (s_axi_araddr == pcg_pkg::OFF_IRQ_STATUS) begin
        rdata_d = {30'h0, irq_stat_q};
      end else if (s_axi_araddr == pcg_pkg::OFF_IRQ_ENABLE) begin
        rdata_d = {30'h0, irq_en_q};
      end else begin
        rdata_d = 32'h0;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    fault_d = periph_access & ~gate_q;
    irq_d   = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      run_one_q    <= pcg_pkg::RST_RUN_ONE;
      // The documented deep-sleep reset value sets only a reserved bit,
      // which reads back as zero, so the implemented image is masked.
      deep_zero_q  <= pcg_pkg::RST_DEEP_ZERO & pcg_pkg::MASK_GROUP_ZERO;
      sleep_one_q  <= pcg_pkg::RST_SLEEP_ONE;
      sleep_zero_q <= pcg_pkg::RST_SLEEP_ZERO;
      run_zero_q   <= pcg_pkg::RST_RUN_ZERO;
      deep_one_q   <= pcg_pkg::RST_DEEP_ONE;
      auto_gate_q  <= 1'b0;
      irq_stat_q   <= '0;
      irq_en_q     <= '0;
      awready_q    <= 1'b1;
      wready_q     <= 1'b1;
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= 12'h0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      bvalid_q     <= 1'b0;
      bresp_q      <= 2'b00;
      arready_q    <= 1'b1;
      rvalid_q     <= 1'b0;
      rdata_q      <= 32'h0;
      rresp_q      <= 2'b00;
      fault_q      <= 9'h0;
      irq_q        <= 1'b0;
      gate_prev_q  <= '0;
    end else begin
      run_one_q    <= run_one_d;
      deep_zero_q  <= deep_zero_d;
      sleep_one_q  <= sleep_one_d;
      sleep_zero_q <= sleep_zero_d;
      run_zero_q   <= run_zero_d;
      deep_one_q   <= deep_one_d;
      auto_gate_q  <= auto_gate_d;
      irq_stat_q   <= irq_stat_d;
      irq_en_q     <= irq_en_d;
      awready_q    <= awready_d;
      wready_q     <= wready_d;
      aw_got_q     <= aw_got_d;
      w_got_q      <= w_got_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      wstrb_q      <= wstrb_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      arready_q    <= arready_d;
      rvalid_q     <= rvalid_d;
      rdata_q      <= rdata_d;
      rresp_q      <= rresp_d;
      fault_q      <= fault_d;
      irq_q        <= irq_d;
      gate_prev_q  <= gate_q;
    end
  end

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign periph_clock_en = gate_q;
  assign periph_fault    = fault_q;
  assign irq             = irq_q;
endmodule
`default_nettype wire

// ==== test/pcg_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module pcg_checker (
  input wire logic                clock,
  input wire logic                reset,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire pcg_pkg::pcg_power_t power_state,
  input wire logic [8:0]          periph_access,
  input wire logic [8:0]          periph_clock_en,
  input wire logic [8:0]          periph_fault,
  input wire logic                irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_fault;
    1'b1 |=> periph_fault == ($past(periph_access) & ~$past(periph_clock_en));
  endproperty
  a_fault: assert property (p_fault) else $error("fault not access of gated unit");
  property p_rst;
    $past(reset) |-> periph_clock_en == 9'h000 && periph_fault == 9'h000 && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == pcg_pkg::RESP_OKAY;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answered with an error");
  property p_rresp;
    s_axi_rvalid |-> s_axi_rresp == pcg_pkg::RESP_OKAY;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answered with an error");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  // Enables may move only after a write answer or a power-state change.
  property p_stable;
    power_state == $past(power_state) && $past(power_state) == $past(power_state, 2)
      && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) |-> $stable(periph_clock_en);
  endproperty
  a_stable: assert property (p_stable) else $error("enable changed without cause");
  c_fault: cover property (periph_fault != 9'h000);
  c_irq: cover property (irq);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pcg_top pcg_checker chk (.clock, .reset, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_state,
  .periph_access, .periph_clock_en, .periph_fault, .irq);
`default_nettype wire

// ==== test/peripheral_clock_gating_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gating_test;
  logic                clock, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic                s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [11:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata, rd, g0, g1, s0, s1, d0, d1;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [8:0]          periph_access, periph_clock_en, periph_fault, acc;
  pcg_pkg::pcg_power_t power_state;
  int                  fail_count, comparisons;

  pcg_top uut (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_state, .periph_access, .periph_clock_en,
    .periph_fault, .irq);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [8:0] exp_en(input logic [31:0] a, input logic [31:0] z);
    return {z[16], z[3], a[18], a[17], a[16], a[12], a[4], a[1], a[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Both tasks end one edge after releasing ready, so a following call never
  // drives the same signal twice in one time step.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check(32'(s_axi_bresp), 32'(pcg_pkg::RESP_OKAY));
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    check(rd & m, e);
    check(32'(s_axi_rresp), 32'(pcg_pkg::RESP_OKAY));
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic settle_power(input pcg_pkg::pcg_power_t p);
    power_state <= p;
    repeat (3) @(posedge clock);
  endtask

  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    periph_access = 9'h000;
    power_state = pcg_pkg::PCG_RUN;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'he470));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check(32'(periph_clock_en), 32'h0);
    rdc(pcg_pkg::OFF_RUN_ONE, 32'h0, 32'hffffffff);
    rdc(pcg_pkg::OFF_DEEP_ZERO, 32'h0, 32'hffffffff);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      g1 = (i == 0) ? 32'hffffffff : $urandom;
      d0 = (i == 0) ? 32'hffffffff : $urandom;
      g0 = $urandom;
      s0 = $urandom;
      s1 = $urandom;
      d1 = $urandom;
      wr(pcg_pkg::OFF_RUN_ONE, g1);
      wr(pcg_pkg::OFF_RUN_ZERO, g0);
      wr(pcg_pkg::OFF_DEEP_ZERO, d0);
      wr(pcg_pkg::OFF_DEEP_ONE, d1);
      wr(pcg_pkg::OFF_SLEEP_ZERO, s0);
      wr(pcg_pkg::OFF_SLEEP_ONE, s1);
      rdc(pcg_pkg::OFF_RUN_ONE, g1 & 32'h00071013, 32'hffffffff);
      rdc(pcg_pkg::OFF_DEEP_ZERO, d0 & 32'h00010008, 32'hffffffff);
      check(32'(periph_clock_en), 32'(exp_en(g1, g0)));
    end
    $display("Test register fields done");
    settle_power(pcg_pkg::PCG_DEEP);
    check(32'(periph_clock_en), 32'(exp_en(g1, g0)));
    wr(pcg_pkg::OFF_AUTO_CTRL, 32'h1);
    check(32'(periph_clock_en), 32'(exp_en(d1, d0)));
    settle_power(pcg_pkg::PCG_SLEEP);
    check(32'(periph_clock_en), 32'(exp_en(s1, s0)));
    settle_power(pcg_pkg::PCG_RUN);
    check(32'(periph_clock_en), 32'(exp_en(g1, g0)));
    $display("Test power states done");
    // Software keeps reserved bits by writing back what it read.
    rdc(pcg_pkg::OFF_RUN_ONE, g1 & pcg_pkg::MASK_GROUP_ONE, 32'hffffffff);
    g1 = rd | 32'h00000010;
    wr(pcg_pkg::OFF_RUN_ONE, g1);
    check(32'(periph_clock_en), 32'(exp_en(g1, g0)));
    s_axi_wstrb <= 4'h4;
    wr(pcg_pkg::OFF_RUN_ONE, 32'hffffffff);
    s_axi_wstrb <= 4'hf;
    g1 = (g1 & 32'hff00ffff) | 32'h00070000;
    rdc(pcg_pkg::OFF_RUN_ONE, g1, 32'hffffffff);
    check(32'(periph_clock_en), 32'(exp_en(g1, g0)));
    $display("Test read-modify-write done");
    g1 = 32'h0;
    wr(pcg_pkg::OFF_RUN_ONE, g1);
    wr(pcg_pkg::OFF_IRQ_ENABLE, 32'h1);
    rdc(pcg_pkg::OFF_IRQ_STATUS, 32'h2, 32'h2);
    wr(pcg_pkg::OFF_IRQ_CLEAR, 32'h3);
    check(32'(irq), 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(pcg_pkg::OFF_IRQ_ENABLE, 32'(k == 0));
      acc = 9'($urandom) | 9'h001;
      periph_access <= acc;
      @(posedge clock);
      periph_access <= 9'h000;
      @(posedge clock);
      check(32'(periph_fault), 32'(acc & ~exp_en(g1, g0)));
      check(32'(irq), 32'(k == 0));
      rdc(pcg_pkg::OFF_IRQ_STATUS, 32'h1, 32'h1);
      wr(pcg_pkg::OFF_IRQ_CLEAR, 32'h3);
      check(32'(irq), 32'h0);
    end
    // An access held across the clear must leave the fault bit set.
    periph_access <= 9'h001;
    wr(pcg_pkg::OFF_IRQ_CLEAR, 32'h3);
    periph_access <= 9'h000;
    rdc(pcg_pkg::OFF_IRQ_STATUS, 32'h1, 32'h1);
    rdc(pcg_pkg::OFF_IRQ_CLEAR, 32'h0, 32'hffffffff);
    $display("Test bus faults done");
    wr(12'h1f0, $urandom);
    rdc(12'h1f0, 32'h0, 32'hffffffff);
    $display("Test unmapped access done");
    complete_run();
  end

  initial begin
    #(50 * 20000);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
